// ==== design/qtu_pkg.sv ====
// Shared constants and types for the four-channel counter/timer unit.
package qtu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Channel count and which channels own a zero-count pin.
  localparam int unsigned QTU_NUM_CH = 4;
  localparam int unsigned QTU_ZC_CH = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions inside a control word.
  localparam int unsigned QTU_CTL_IRQ_EN = 7;
  localparam int unsigned QTU_CTL_COUNTER = 6;
  localparam int unsigned QTU_CTL_PRE256 = 5;
  localparam int unsigned QTU_CTL_RISING = 4;
  localparam int unsigned QTU_CTL_TRIG = 3;
  localparam int unsigned QTU_CTL_TC_NEXT = 2;
  localparam int unsigned QTU_CTL_SWRST = 1;
  localparam int unsigned QTU_CTL_IS_CTRL = 0;

  // Vector layout: host bits on top, channel number, then a zero.
  localparam int unsigned QTU_VEC_HI_LSB = 3;
  localparam int unsigned QTU_VEC_CH_LSB = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] QTU_CTRL_RST = 8'h00;
  localparam logic [7:0] QTU_TC_RST = 8'h00;
  localparam logic [7:0] QTU_CNT_RST = 8'h00;
  localparam logic [4:0] QTU_VEC_RST = 5'h00;
  localparam logic [7:0] QTU_DOUT_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler terminal counts: divide by 16 and by 256.
  localparam logic [7:0] QTU_PRE16_MAX = 8'h0F;
  localparam logic [7:0] QTU_PRE256_MAX = 8'hFF;
  localparam logic [7:0] QTU_PRE_RST = 8'h00;

  // The down-counter reaches zero on the tick taken while it holds one.
  localparam logic [7:0] QTU_CNT_LAST = 8'h01;

  // Channel phase: stopped, waiting for a trigger edge, or counting.
  typedef enum logic [1:0] {
    QTU_IDLE,
    QTU_ARMED,
    QTU_RUN
  } qtu_phase_t;

endpackage : qtu_pkg

// ==== design/qtu_sync.sv ====
// Two-flop synchroniser for a group of asynchronous input levels.
`timescale 1ns/1ps
`default_nettype none
module qtu_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk,               // System clock.
  input wire logic rstn,                  // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in,  // Levels from outside the clock domain.
  output logic [WIDTH-1:0] sync_out       // Levels after two flops.
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } qtu_sync_t;

  qtu_sync_t s_q;
  qtu_sync_t s_d;

  always_comb begin
    s_d.meta = async_in;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stab;

endmodule : qtu_sync
`default_nettype wire

// ==== design/qtu_prescaler.sv ====
// Per-channel prescaler dividing the system clock by 16 or 256.
`timescale 1ns/1ps
`default_nettype none
module qtu_prescaler
  import qtu_pkg::*;
(
  input wire logic sys_clk,  // System clock.
  input wire logic rstn,     // Asynchronous reset, active low.
  input wire logic clr,      // Hold the prescaler at zero.
  input wire logic sel256,   // High divides by 256, low by 16.
  output logic tick          // One-cycle pulse per prescaler period.
);

  typedef struct packed {
    logic [7:0] cnt;
  } qtu_pre_t;

  qtu_pre_t p_q;
  qtu_pre_t p_d;
  logic [7:0] last;

  always_comb begin
    p_d = p_q;
    last = sel256 ? QTU_PRE256_MAX : QTU_PRE16_MAX;
    tick = 1'b0;
    if (clr) begin
      p_d.cnt = QTU_PRE_RST;
    end else if (p_q.cnt >= last) begin
      // A divisor change mid-period wraps at once instead of running to 255.
      p_d.cnt = QTU_PRE_RST;
      tick = 1'b1;
    end else begin
      p_d.cnt = p_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      p_q.cnt <= QTU_PRE_RST;
    end else begin
      p_q <= p_d;
    end
  end

endmodule : qtu_prescaler
`default_nettype wire

// ==== design/qtu_top.sv ====
// Four-channel counter/timer unit with host I/O bus and vectored requests.
//
// Functional notes
// RQ1: Four channels; channel 0 highest priority.
// RQ2: Each channel yields its own interrupt vector.
// RQ3: Per channel: reload, control, count, prescaler.
// RQ4: Channel selects route each access.
// RQ5: Bit 0 set is control, clear vector.
// RQ6: Bit 7 enables interrupt; bit 1 resets.
// RQ7: Bit 6 set counts external edges.
// RQ8: Bit 6 clear counts prescaler pulses.
// RQ9: Prescaler timer-only, divides 256 or 16.
// RQ10: Bit 4 picks edge; bit 3 edge-starts timer.
// RQ11: Bit 3 clear starts timer on load.
// RQ12: Bit 2 set: next byte is reload.
// RQ13: Reload follows control word, counts 1-256.
// RQ14: First reload value copied into counter.
// RQ15: At zero, reload and keep counting.
// RQ16: New reload used only at next zero.
// RQ17: Zero count pulses the zero-count output.
// RQ18: Only channels 0-2 have zero-count outputs.
// RQ19: Read returns selected live down-counter.
// RQ20: Enabled channel requests interrupt at zero.
// RQ21: Selects form binary number, high bit second.
// RQ22: Vector: host bits, channel number, zero.
// RQ23: Reload byte zero means 256 counts.
// RQ24: Software reset stops channel until reload written.
// RQ25: One-cycle pulse; external edges synchronised.
`timescale 1ns/1ps
`default_nettype none
module qtu_top
  import qtu_pkg::*;
(
  input wire logic sys_clk,             // System clock, 25 MHz.
  input wire logic rstn,                // Asynchronous reset, active low.
  input wire logic ce_n,                // Chip enable, active low.
  input wire logic iorq_n,              // I/O request, active low.
  input wire logic rd_n,                // Read strobe, active low.
  input wire logic m1_n,                // Machine cycle one, active low.
  input wire logic chan_sel_lo,         // Channel select, low bit.
  input wire logic chan_sel_hi,         // Channel select, high bit.
  input wire logic [7:0] data_in,       // Data bus, input side.
  output logic [7:0] data_out,          // Data bus, output side.
  output logic data_oe,                 // Data bus drive enable.
  input wire logic [3:0] ext_edge_input,  // External clock/trigger per channel.
  output logic [2:0] zero_count_pulse,  // Zero-count pulses, channels 0 to 2.
  output logic int_req                  // Any enabled channel has a request.
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation. Strobes are inverted ahead of the first flop so
  // that the reset value of zero reads as an idle bus.

  logic [13:0] bus_s;
  logic [3:0] ext_s;
  logic ce_s;
  logic iorq_s;
  logic rd_s;
  logic m1_s;
  logic [1:0] sel;
  logic [7:0] din_s;

  qtu_sync #(.WIDTH(14)) u_bus_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in({~ce_n, ~iorq_n, ~rd_n, ~m1_n, chan_sel_hi, chan_sel_lo, data_in}),
    .sync_out(bus_s)
  );

  qtu_sync #(.WIDTH(4)) u_ext_sync (  // [RQ25]
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(ext_edge_input),
    .sync_out(ext_s)
  );

  assign ce_s = bus_s[13];
  assign iorq_s = bus_s[12];
  assign rd_s = bus_s[11];
  assign m1_s = bus_s[10];
  assign sel = bus_s[9:8];  // [RQ21]
  assign din_s = bus_s[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [3:0][7:0] ctrl;  // [RQ3]
    logic [3:0][7:0] tc;
    logic [3:0][7:0] cnt;
    qtu_phase_t [3:0] phase;
    logic [3:0] expect_tc;
    logic [3:0] pend;
    logic [3:0] ext_prev;
    logic [2:0] zc;
    logic [4:0] vec_hi;
    logic wr_prev;
    logic rd_prev;
    logic ack_prev;
    logic [7:0] dout;
    logic doe;
  } qtu_state_t;

  qtu_state_t q;
  qtu_state_t d;

  logic wr_now;
  logic rd_now;
  logic ack_now;
  logic wr_start;
  logic rd_start;
  logic ack_start;
  logic [3:0] edge_hit;
  logic [3:0] ptick;
  logic [3:0] tick;
  logic [3:0] zero;
  logic [3:0] pre_clr;

  // Lowest-numbered pending channel wins the vector.
  function automatic logic [1:0] qtu_pick(input logic [3:0] p);
    logic [1:0] r;
    r = 2'h0;
    for (int i = QTU_NUM_CH - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : qtu_pick

  assign wr_now = ce_s & iorq_s & ~rd_s & ~m1_s;
  assign rd_now = ce_s & iorq_s & rd_s & ~m1_s;
  assign ack_now = iorq_s & m1_s;
  assign wr_start = wr_now & ~q.wr_prev;
  assign rd_start = rd_now & ~q.rd_prev;
  assign ack_start = ack_now & ~q.ack_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Prescalers, run only while a timer channel counts.

  for (genvar g = 0; g < QTU_NUM_CH; g++) begin : g_pre
    assign pre_clr[g] = (q.phase[g] != QTU_RUN) | q.ctrl[g][QTU_CTL_COUNTER];  // [RQ9]
    qtu_prescaler u_pre (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clr(pre_clr[g]),
      .sel256(q.ctrl[g][QTU_CTL_PRE256]),  // [RQ9]
      .tick(ptick[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    d = q;
    d.zc = '0;
    d.wr_prev = wr_now;
    d.rd_prev = rd_now;
    d.ack_prev = ack_now;
    for (int c = 0; c < QTU_NUM_CH; c++) begin
      edge_hit[c] = q.ctrl[c][QTU_CTL_RISING] ? (ext_s[c] & ~q.ext_prev[c])
                                               : (~ext_s[c] & q.ext_prev[c]);  // [RQ10]
      tick[c] = q.ctrl[c][QTU_CTL_COUNTER] ? edge_hit[c] : ptick[c];  // [RQ7] [RQ8]
      zero[c] = 1'b0;
      d.ext_prev[c] = ext_s[c];
      case (q.phase[c])
        QTU_IDLE: begin
        end
        QTU_ARMED: begin
          if (edge_hit[c]) begin
            d.phase[c] = QTU_RUN;  // [RQ10]
          end
        end
        QTU_RUN: begin
          if (tick[c]) begin
            if (q.cnt[c] == QTU_CNT_LAST) begin
              d.cnt[c] = q.tc[c];  // [RQ15] [RQ16]
              zero[c] = 1'b1;
            end else begin
              // A reload of zero wraps to 255 here and so spans 256 ticks.
              d.cnt[c] = q.cnt[c] - 8'h01;  // [RQ23]
            end
          end
        end
        default: begin
          d.phase[c] = QTU_IDLE;
        end
      endcase
    end

    // Bus side: a read, or an acknowledge while a request is pending, drives the bus for its duration.
    if (rd_start) begin
      d.dout = q.cnt[sel];  // [RQ19]
      d.doe = 1'b1;
    end else if (ack_start && (q.pend != 4'h0)) begin
      d.dout = {q.vec_hi, qtu_pick(q.pend), 1'b0};  // [RQ2] [RQ22] [RQ1]
      d.doe = 1'b1;
      d.pend[qtu_pick(q.pend)] = 1'b0;
    end else if (!rd_now && !ack_now) begin
      d.doe = 1'b0;
    end

    // Zero events set requests after the acknowledge clear, so set wins.
    for (int c = 0; c < QTU_NUM_CH; c++) begin
      if (zero[c]) begin
        if (c < QTU_ZC_CH) begin
          d.zc[c] = 1'b1;  // [RQ17] [RQ18] [RQ25]
        end
        if (q.ctrl[c][QTU_CTL_IRQ_EN]) begin
          d.pend[c] = 1'b1;  // [RQ20] [RQ6]
        end
      end
    end

    // Host writes, routed by the channel select code.
    if (wr_start) begin  // [RQ4]
      if (q.expect_tc[sel]) begin
        d.tc[sel] = din_s;  // [RQ12] [RQ13]
        d.expect_tc[sel] = 1'b0;
        if (q.phase[sel] != QTU_RUN) begin
          d.cnt[sel] = din_s;  // [RQ14]
          if (q.ctrl[sel][QTU_CTL_COUNTER] || !q.ctrl[sel][QTU_CTL_TRIG]) begin
            d.phase[sel] = QTU_RUN;  // [RQ11]
          end else begin
            d.phase[sel] = QTU_ARMED;  // [RQ10]
          end
        end
      end else if (din_s[QTU_CTL_IS_CTRL]) begin  // [RQ5]
        d.ctrl[sel] = din_s;
        d.expect_tc[sel] = din_s[QTU_CTL_TC_NEXT];  // [RQ12]
        if (din_s[QTU_CTL_SWRST]) begin
          // Stopped until the next reload byte; pulses already due are dropped.
          d.phase[sel] = QTU_IDLE;  // [RQ6] [RQ24]
          d.pend[sel] = 1'b0;
          d.zc = d.zc & ~(3'h1 << sel);
        end
      end else begin
        d.vec_hi = din_s[7:QTU_VEC_HI_LSB];  // [RQ5]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < QTU_NUM_CH; c++) begin
        q.ctrl[c] <= QTU_CTRL_RST;
        q.tc[c] <= QTU_TC_RST;
        q.cnt[c] <= QTU_CNT_RST;
        q.phase[c] <= QTU_IDLE;
      end
      q.expect_tc <= '0;
      q.pend <= '0;
      q.ext_prev <= '0;
      q.zc <= '0;
      q.vec_hi <= QTU_VEC_RST;
      q.wr_prev <= 1'b0;
      q.rd_prev <= 1'b0;
      q.ack_prev <= 1'b0;
      q.dout <= QTU_DOUT_RST;
      q.doe <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign data_out = q.dout;
  assign data_oe = q.doe;
  assign zero_count_pulse = q.zc;
  assign int_req = |q.pend;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_zc_one_cycle: assert property (q.zc[0] |=> !q.zc[0])  // [RQ25]
    else $error("zero-count pulse longer than one cycle");

  a_zero_reload: assert property (zero[0] && !(wr_start && sel == 2'h0)  // [RQ15]
      |=> q.cnt[0] == $past(q.tc[0]))
    else $error("counter not reloaded at zero");

  a_zero_pulse: assert property (zero[1] && !(wr_start && sel == 2'h1)  // [RQ17]
      |=> zero_count_pulse[1])
    else $error("no zero-count pulse after zero");

  a_irq_on_zero: assert property (zero[2] && q.ctrl[2][QTU_CTL_IRQ_EN]  // [RQ20]
      && !(wr_start && sel == 2'h2) |=> q.pend[2])
    else $error("enabled zero did not raise a request");

  a_irq_masked: assert property (!q.pend[3] && !q.ctrl[3][QTU_CTL_IRQ_EN] |=> !q.pend[3])  // [RQ6]
    else $error("request raised while disabled");

  a_read_count: assert property (rd_start |=> data_oe && data_out == $past(q.cnt[sel]))  // [RQ19]
    else $error("read did not return the live count");

  a_vector_form: assert property (ack_start && !rd_start && q.pend != 4'h0  // [RQ22]
      |=> data_out[0] == 1'b0 && data_out[7:3] == $past(q.vec_hi)
          && data_out[2:1] == $past(qtu_pick(q.pend)))
    else $error("interrupt vector malformed");

  a_timer_hold: assert property (q.phase[0] == QTU_RUN && !q.ctrl[0][QTU_CTL_COUNTER]  // [RQ8]
      && !ptick[0] && !wr_start |=> $stable(q.cnt[0]))
    else $error("timer counted without a prescaler pulse");

  a_swrst_stops: assert property (wr_start && sel == 2'h0 && !q.expect_tc[0]  // [RQ24]
      && din_s[QTU_CTL_IS_CTRL] && din_s[QTU_CTL_SWRST]
      |=> q.phase[0] == QTU_IDLE ##1 q.phase[0] == QTU_IDLE)
    else $error("software reset did not stop the channel");

  c_zero_event: cover property (zero[0] ##1 zero_count_pulse[0]);
  c_vector_ack: cover property (ack_start && q.pend != 4'h0);
  c_count_read: cover property (rd_start && q.phase[sel] == QTU_RUN);

endmodule : qtu_top
`default_nettype wire

// ==== sim/qtu_host.sv ====
// Host processor model that drives the unit's I/O bus pins.
`timescale 1ns/1ps
`default_nettype none
module qtu_host (
  input wire logic sys_clk, // System clock.
  output logic ce_n, // Chip enable, active low.
  output logic iorq_n, // I/O request, active low.
  output logic rd_n, // Read strobe, active low.
  output logic m1_n, // Cycle one, active low.
  output logic chan_sel_lo, // Channel select, low bit.
  output logic chan_sel_hi, // Channel select, high bit.
  output logic [7:0] data_in, // Bus towards the unit.
  input wire logic [7:0] data_out, // Bus from the unit.
  input wire logic data_oe // Unit drives the bus.
);
  initial begin
    {ce_n, iorq_n, rd_n, m1_n} = 4'hF;
    {chan_sel_hi, chan_sel_lo} = 2'h0;
    data_in = 8'h5A;
  end
  ////////////////////////////////////////////////////////////
  // Strobes are held four cycles because the unit synchronises the pins first.
  task automatic wr(input logic [1:0] ch, input logic [7:0] v);
    @(posedge sys_clk);
    {chan_sel_hi, chan_sel_lo} <= ch;
    data_in <= v;
    {ce_n, iorq_n} <= 2'h0;
    repeat (4) @(posedge sys_clk);
    {ce_n, iorq_n} <= 2'h3;
    // A released bus shows the inverse, so a stale byte is never mistaken for data.
    data_in <= ~v;
    repeat (3) @(posedge sys_clk);
  endtask : wr
  // Read, or acknowledge when ack is high; ok stays low if the unit never drove.
  task automatic rd(input logic [1:0] ch, input logic ack, output logic [7:0] v, output logic ok);
    int n;
    ok = 1'b0;
    v = 8'h00;
    @(posedge sys_clk);
    {chan_sel_hi, chan_sel_lo} <= ch;
    {ce_n, iorq_n, rd_n, m1_n} <= ack ? 4'hA : 4'h1;
    for (n = 0; n < 10 && ok == 1'b0; n++) begin
      @(posedge sys_clk);
      if (data_oe === 1'b1) begin
        ok = 1'b1;
        v = data_out;
      end
    end
    {ce_n, iorq_n, rd_n, m1_n} <= 4'hF;
    for (n = 0; n < 8 && data_oe !== 1'b0; n++) begin
      @(posedge sys_clk);
    end
    if (data_oe !== 1'b0) ok = 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : rd
endmodule : qtu_host
`default_nettype wire

// ==== sim/qtu_top_tb_top.sv ====
// Self-checking bench for the four-channel counter/timer unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module qtu_top_tb_top;
  import qtu_pkg::*;
  logic sys_clk, rstn, ce_n, iorq_n, rd_n, m1_n, chan_sel_lo, chan_sel_hi, data_oe, int_req, ok;
  logic [7:0] data_in, data_out, b;
  logic [3:0] ext;
  logic [2:0] zcp;
  int error_cnt = 0, check_count = 0, n;
  int zc_cnt [3] = '{0, 0, 0};
  qtu_top dut (.sys_clk, .rstn, .ce_n, .iorq_n, .rd_n, .m1_n, .chan_sel_lo, .chan_sel_hi, .data_in,
    .data_out, .data_oe, .ext_edge_input(ext), .zero_count_pulse(zcp), .int_req);
  qtu_host host (.sys_clk, .ce_n, .iorq_n, .rd_n, .m1_n, .chan_sel_lo, .chan_sel_hi, .data_in,
    .data_out, .data_oe);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) if (zcp[i] === 1'b1) zc_cnt[i]++;
  end
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic hang();
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict();
  endtask : hang
  task automatic rdc(input logic [1:0] ch, input logic ack, input logic [7:0] e);
    host.rd(ch, ack, b, ok);
    if (ok !== 1'b1) hang();
    `CHK(b, e)
  endtask : rdc
  // Two calls in a row give the pulse period less one.
  task automatic zc(input int c, output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      if (k > 5000) hang();
    end while (zcp[c] !== 1'b1);
    @(posedge sys_clk);
    `CHK(zcp[c], 1'b0)
  endtask : zc
  task automatic pulse(input logic [3:0] m);
    ext <= ext | m;
    repeat (6) @(posedge sys_clk);
    ext <= ext & ~m;
    repeat (6) @(posedge sys_clk);
  endtask : pulse
  initial begin
    rstn = 1'b0;
    ext = 4'h0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    `CHK({data_oe, int_req, zcp}, 5'h00)
    rdc(2'd0, 1'b0, QTU_CNT_RST);
    host.rd(2'd0, 1'b1, b, ok);
    `CHK(ok, 1'b0)
    $display("Test reset done");
    // A reload byte with bit 0 set is still a reload.
    host.wr(2'd0, 8'hA8);
    host.wr(2'd0, 8'h85);
    host.wr(2'd0, 8'h03);
    zc(0, n);
    zc(0, n);
    `CHK(n, 47)
    `CHK(int_req, 1'b1)
    rdc(2'd0, 1'b1, 8'hA8);
    host.wr(2'd0, 8'h03);
    n = zc_cnt[0];
    repeat (200) @(posedge sys_clk);
    `CHK(zc_cnt[0], n)
    `CHK(int_req, 1'b0)
    $display("Test timer done");
    host.wr(2'd0, 8'h25);
    host.wr(2'd0, 8'h02);
    zc(0, n);
    // A new reload needs its own control word with bit 2 set.
    host.wr(2'd0, 8'h25);
    host.wr(2'd0, 8'h01);
    zc(0, n);
    // The two writes above used sixteen cycles of the old 512-cycle period.
    `CHK(n, 495)
    zc(0, n);
    `CHK(n, 255)
    `CHK(int_req, 1'b0)
    host.wr(2'd0, 8'h07);
    host.wr(2'd0, 8'h00);
    zc(0, n);
    zc(0, n);
    `CHK(n, 4095)
    host.wr(2'd0, 8'h03);
    $display("Test prescaler done");
    host.wr(2'd1, 8'hD5);
    host.wr(2'd1, 8'h02);
    pulse(4'h2);
    rdc(2'd1, 1'b0, 8'h01);
    rdc(2'd2, 1'b0, 8'h00);
    pulse(4'h2);
    `CHK(zc_cnt[1], 1)
    rdc(2'd1, 1'b0, 8'h02);
    rdc(2'd0, 1'b1, 8'hAA);
    $display("Test counter done");
    host.wr(2'd2, 8'hC5);
    host.wr(2'd2, 8'h01);
    host.wr(2'd3, 8'hC5);
    host.wr(2'd3, 8'h01);
    pulse(4'hC);
    `CHK(zc_cnt[2], 1)
    rdc(2'd0, 1'b1, 8'hAC);
    rdc(2'd0, 1'b1, 8'hAE);
    `CHK(int_req, 1'b0)
    $display("Test priority done");
    host.wr(2'd1, 8'h1F);
    host.wr(2'd1, 8'h01);
    n = zc_cnt[1];
    repeat (100) @(posedge sys_clk);
    `CHK(zc_cnt[1], n)
    pulse(4'h2);
    zc(1, n);
    zc(1, n);
    `CHK(n, 15)
    $display("Test trigger done");
    give_verdict();
  end
endmodule : qtu_top_tb_top
`default_nettype wire
